/* src/evr_pkg.sv */
// Shared constants and carrier types for the event routing configuration block
package evr_pkg;

  // Sizes
  localparam int NUM_CH = 8;
  localparam int NUM_GEN = 59;
  localparam int NUM_USER = 14;
  localparam int GEN_IDX_W = 6;
  localparam int CH_IDX_W = 3;
  localparam int USER_IDX_W = 4;
  localparam int ADR_W = 4;

  // Register byte addresses
  localparam logic [ADR_W-1:0] ADR_CHANNEL = 4'h4;
  localparam logic [ADR_W-1:0] ADR_USER = 4'h8;

  // Channel configuration register fields
  localparam int CH_SEL_LSB = 0;
  localparam int SOFTWARE_EVENT_INJECT_BIT = 8;
  localparam int GEN_LSB = 16;
  localparam int PATH_LSB = 24;
  localparam int EDGE_LSB = 26;

  // User multiplexer register fields
  localparam int USER_SEL_LSB = 0;
  localparam int USER_CH_LSB = 8;

  // Byte lanes
  localparam int LANE_0 = 0;
  localparam int LANE_1 = 1;
  localparam int LANE_2 = 2;
  localparam int LANE_3 = 3;

  // Code ranges
  localparam logic [7:0] GEN_NONE = 8'h00;
  localparam logic [7:0] GEN_LAST = 8'h3B;
  localparam logic [7:0] GEN_BASE = 8'h01;
  localparam logic [7:0] CH_LAST = 8'h07;
  localparam logic [7:0] USER_CH_NONE = 8'h00;
  localparam logic [7:0] USER_CH_LAST = 8'h08;
  localparam logic [7:0] USER_CH_BASE = 8'h01;
  localparam logic [7:0] USER_LAST = 8'h0D;

  // Reset values
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [31:0] RDAT_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    PATH_SYNC = 2'h0,
    PATH_RESYNC = 2'h1,
    PATH_ASYNC = 2'h2,
    PATH_RSVD = 2'h3
  } evr_path_t;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } evr_edge_t;

  typedef struct packed {
    evr_edge_t edge_detect_select;
    evr_path_t path;
    logic [7:0] generator_select;
  } evr_chcfg_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } evr_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } evr_wb_rsp_t;

endpackage

/* src/evr_user_mem.sv */
// Per-user channel map storage with a registered read port and a parallel view
`timescale 1ns/1ps
module evr_user_mem (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [evr_pkg::USER_IDX_W-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // Read port
  input wire logic [evr_pkg::USER_IDX_W-1:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // All entries, for routing
  output logic [evr_pkg::NUM_USER-1:0][7:0] map_o
);

  typedef struct packed {
    logic [evr_pkg::NUM_USER-1:0][7:0] mem;
    logic [7:0] rd;
  } evr_mem_state_t;

  evr_mem_state_t s;
  evr_mem_state_t next_s;

  always_comb begin
    next_s = s;
    if (wr_en_i && (int'(wr_addr_i) < evr_pkg::NUM_USER)) begin
      next_s.mem[wr_addr_i] = wr_data_i;
    end
    // Out of range entries read as no channel
    if (int'(rd_addr_i) < evr_pkg::NUM_USER) begin
      next_s.rd = s.mem[rd_addr_i];
    end else begin
      next_s.rd = evr_pkg::USER_CH_NONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o = s.rd;
  assign map_o = s.mem;

endmodule

/* src/evr_route.sv */
// Event routing unit configuration and channel/user event routing
`timescale 1ns/1ps
module evr_route (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire evr_pkg::evr_wb_req_t wb_req_i,
  output evr_pkg::evr_wb_rsp_t wb_rsp_o,
  // Generator events, bit k is generator code k plus one
  input wire logic [evr_pkg::NUM_GEN-1:0] gen_evt_i,
  // Channel and user events
  output logic [evr_pkg::NUM_CH-1:0] ch_evt_o,
  output logic [evr_pkg::NUM_USER-1:0] user_evt_o
);

  typedef struct packed {
    evr_pkg::evr_chcfg_t [evr_pkg::NUM_CH-1:0] cfg;
    logic [7:0] ch_sel;
    logic [7:0] user_sel;
    logic [evr_pkg::NUM_GEN-1:0] sync1;
    logic [evr_pkg::NUM_GEN-1:0] sync2;
    logic [evr_pkg::NUM_GEN-1:0] sync3;
    logic [evr_pkg::NUM_GEN-1:0] stable;
    logic [evr_pkg::NUM_CH-1:0] prev;
    logic [evr_pkg::NUM_CH-1:0] ch_evt;
    logic [evr_pkg::NUM_USER-1:0] user_evt;
    logic ack;
    logic [31:0] rdat;
  } evr_state_t;

  evr_state_t s;
  evr_state_t next_s;

  logic [evr_pkg::NUM_CH-1:0] src_lvl;
  logic [evr_pkg::NUM_CH-1:0] hw_evt;
  logic [7:0] mem_rd;
  logic [evr_pkg::NUM_USER-1:0][7:0] user_map;
  logic mem_wr;
  logic [7:0] mem_wdata;
  logic [evr_pkg::USER_IDX_W-1:0] mem_waddr;

  function automatic logic evr_gen_ok(input logic [7:0] code);
    evr_gen_ok = (code != evr_pkg::GEN_NONE) && (code <= evr_pkg::GEN_LAST);
  endfunction

  function automatic logic [evr_pkg::GEN_IDX_W-1:0] evr_gen_idx(input logic [7:0] code);
    logic [7:0] t;
    t = code - evr_pkg::GEN_BASE;
    evr_gen_idx = t[evr_pkg::GEN_IDX_W-1:0];
  endfunction

  function automatic logic evr_ch_ok(input logic [7:0] sel);
    evr_ch_ok = (sel <= evr_pkg::CH_LAST);
  endfunction

  function automatic logic evr_user_ok(input logic [7:0] sel);
    evr_user_ok = (sel <= evr_pkg::USER_LAST);
  endfunction

  function automatic logic evr_event(input evr_pkg::evr_chcfg_t c, input logic lvl,
                                     input logic prv);
    evr_event = 1'b0;
    case (c.path)
      evr_pkg::PATH_SYNC, evr_pkg::PATH_RESYNC: begin
        case (c.edge_detect_select)
          evr_pkg::EDGE_RISE: evr_event = lvl & ~prv;
          evr_pkg::EDGE_FALL: evr_event = ~lvl & prv;
          evr_pkg::EDGE_BOTH: evr_event = lvl ^ prv;
          default: evr_event = 1'b0;
        endcase
      end
      // Edge field is ignored here; the level goes straight through
      evr_pkg::PATH_ASYNC: evr_event = lvl;
      default: evr_event = 1'b0;
    endcase
  endfunction

  function automatic logic evr_user_route(input logic [7:0] field,
                                          input logic [evr_pkg::NUM_CH-1:0] ev);
    logic [7:0] t;
    t = field - evr_pkg::USER_CH_BASE;
    evr_user_route = 1'b0;
    // Zero and reserved values disconnect the user
    if ((field != evr_pkg::USER_CH_NONE) && (field <= evr_pkg::USER_CH_LAST)) begin
      evr_user_route = ev[t[evr_pkg::CH_IDX_W-1:0]];
    end
  endfunction

  // Per-channel source selection and edge detection
  genvar ch;
  generate
    for (ch = 0; ch < evr_pkg::NUM_CH; ch++) begin : g_ch
      logic [evr_pkg::GEN_IDX_W-1:0] idx;
      assign idx = evr_gen_idx(s.cfg[ch].generator_select);
      // Resynchronized path reads the filtered copy, the others the raw input
      assign src_lvl[ch] = !evr_gen_ok(s.cfg[ch].generator_select) ? 1'b0 :
                           (s.cfg[ch].path == evr_pkg::PATH_RESYNC) ? s.stable[idx] :
                           gen_evt_i[idx];
      assign hw_evt[ch] = evr_gen_ok(s.cfg[ch].generator_select) &&
                          evr_event(s.cfg[ch], src_lvl[ch], s.prev[ch]);
    end
  endgenerate

  evr_user_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(mem_wr),
    .wr_addr_i(mem_waddr),
    .wr_data_i(mem_wdata),
    .rd_addr_i(s.user_sel[evr_pkg::USER_IDX_W-1:0]),
    .rd_data_o(mem_rd),
    .map_o(user_map)
  );

  always_comb begin
    logic req;
    logic commit;
    logic [evr_pkg::ADR_W-1:0] word_adr;
    logic hit_ch;
    logic hit_user;
    logic [7:0] new_ch;
    logic [7:0] new_user;
    logic [evr_pkg::NUM_CH-1:0] sw_hit;
    logic [31:0] rword;
    logic [evr_pkg::CH_IDX_W-1:0] ci;
    req = wb_req_i.cyc & wb_req_i.stb;
    commit = req & s.ack & wb_req_i.we;
    word_adr = {wb_req_i.adr[evr_pkg::ADR_W-1:2], 2'b00};
    hit_ch = (word_adr == evr_pkg::ADR_CHANNEL);
    hit_user = (word_adr == evr_pkg::ADR_USER);
    new_ch = wb_req_i.sel[evr_pkg::LANE_0] ?
             wb_req_i.dat[evr_pkg::CH_SEL_LSB +: 8] : s.ch_sel;
    new_user = wb_req_i.sel[evr_pkg::LANE_0] ?
               wb_req_i.dat[evr_pkg::USER_SEL_LSB +: 8] : s.user_sel;
    ci = new_ch[evr_pkg::CH_IDX_W-1:0];
    sw_hit = '0;
    rword = '0;
    mem_wr = 1'b0;
    mem_waddr = new_user[evr_pkg::USER_IDX_W-1:0];
    mem_wdata = wb_req_i.dat[evr_pkg::USER_CH_LSB +: 8];
    next_s = s;

    // Three-stage filter; only stages two and three are compared
    next_s.sync1 = gen_evt_i;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    next_s.stable = (s.stable & (s.sync2 ^ s.sync3)) | (s.sync3 & ~(s.sync2 ^ s.sync3));
    next_s.prev = src_lvl;

    // Ack one cycle after the request, dropped the cycle after
    next_s.ack = req & ~s.ack;

    // Writes take effect on the edge that sees ack high
    if (commit && hit_ch) begin
      next_s.ch_sel = new_ch;
      if (evr_ch_ok(new_ch)) begin
        // Inject uses the selector written in the same access
        if (wb_req_i.sel[evr_pkg::LANE_1] && wb_req_i.dat[evr_pkg::SOFTWARE_EVENT_INJECT_BIT]) begin
          sw_hit[ci] = 1'b1;
        end
        if (wb_req_i.sel[evr_pkg::LANE_2]) begin
          next_s.cfg[ci].generator_select = wb_req_i.dat[evr_pkg::GEN_LSB +: 8];
        end
        if (wb_req_i.sel[evr_pkg::LANE_3]) begin
          next_s.cfg[ci].path = evr_pkg::evr_path_t'(wb_req_i.dat[evr_pkg::PATH_LSB +: 2]);
          next_s.cfg[ci].edge_detect_select =
            evr_pkg::evr_edge_t'(wb_req_i.dat[evr_pkg::EDGE_LSB +: 2]);
        end
      end
    end
    if (commit && hit_user) begin
      next_s.user_sel = new_user;
      mem_wr = wb_req_i.sel[evr_pkg::LANE_1] && evr_user_ok(new_user);
    end

    // Read word is captured on the request edge
    if (hit_ch) begin
      rword[evr_pkg::CH_SEL_LSB +: 8] = s.ch_sel;
      if (evr_ch_ok(s.ch_sel)) begin
        rword[evr_pkg::GEN_LSB +: 8] = s.cfg[s.ch_sel[evr_pkg::CH_IDX_W-1:0]].generator_select;
        rword[evr_pkg::PATH_LSB +: 2] = s.cfg[s.ch_sel[evr_pkg::CH_IDX_W-1:0]].path;
        rword[evr_pkg::EDGE_LSB +: 2] =
          s.cfg[s.ch_sel[evr_pkg::CH_IDX_W-1:0]].edge_detect_select;
      end
      rword[evr_pkg::SOFTWARE_EVENT_INJECT_BIT] = 1'b0;
    end else if (hit_user) begin
      rword[evr_pkg::USER_SEL_LSB +: 8] = s.user_sel;
      rword[evr_pkg::USER_CH_LSB +: 8] = evr_user_ok(s.user_sel) ? mem_rd :
                                         evr_pkg::USER_CH_NONE;
    end
    if (req && !s.ack) begin
      next_s.rdat = rword;
    end

    // Software events join the hardware ones on the same channel output
    next_s.ch_evt = hw_evt | sw_hit;
    for (int u = 0; u < evr_pkg::NUM_USER; u++) begin
      next_s.user_evt[u] = evr_user_route(user_map[u], s.ch_evt);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wb_rsp_o.ack = s.ack;
  assign wb_rsp_o.dat = s.rdat;
  assign ch_evt_o = s.ch_evt;
  assign user_evt_o = s.user_evt;

endmodule

/* tb/evr_route_monitor.sv */
// Port checker for the event routing configuration block
`timescale 1ns/1ps
module evr_route_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and events
  input wire evr_pkg::evr_wb_req_t wb_req_i,
  input wire evr_pkg::evr_wb_rsp_t wb_rsp_o,
  input wire logic [evr_pkg::NUM_GEN-1:0] gen_evt_i,
  input wire logic [evr_pkg::NUM_CH-1:0] ch_evt_o,
  input wire logic [evr_pkg::NUM_USER-1:0] user_evt_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rq;
  logic rd;
  logic inj;
  logic [2:0] inj_n;
  assign rq = wb_req_i.cyc && wb_req_i.stb;
  assign rd = rq && wb_rsp_o.ack && !wb_req_i.we;
  assign inj = rq && wb_rsp_o.ack && wb_req_i.we && wb_req_i.adr == evr_pkg::ADR_CHANNEL
    && wb_req_i.sel[1:0] == 2'h3 && wb_req_i.dat[8] && wb_req_i.dat[7:0] <= evr_pkg::CH_LAST;
  // Channel index kept past the ack edge, the master may change data after it
  always_ff @(posedge clk_i) begin
    inj_n <= wb_req_i.dat[2:0];
  end
  AST_ACK_LAT: assert property (rq && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("ack did not follow request");
  AST_ACK_PULSE: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_rsp_o.ack |-> $past(rq))
    else $error("ack without request");
  AST_INJ_RD0: assert property (rd && wb_req_i.adr == evr_pkg::ADR_CHANNEL |-> !wb_rsp_o.dat[8])
    else $error("inject bit read as one");
  AST_UNMAP: assert property (rd && wb_req_i.adr != evr_pkg::ADR_CHANNEL
    && wb_req_i.adr != evr_pkg::ADR_USER |-> wb_rsp_o.dat == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_INJ_FIRE: assert property (inj |=> ch_evt_o[inj_n])
    else $error("software event missing");
  AST_USR_SRC: assert property (|user_evt_o |-> $past(|ch_evt_o))
    else $error("user event without channel event");
  AST_RST: assert property (disable iff (1'b0)
    rst_i |=> !wb_rsp_o.ack && ch_evt_o == '0 && user_evt_o == '0)
    else $error("outputs active after reset");
endmodule
bind evr_route evr_route_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o), .gen_evt_i(gen_evt_i), .ch_evt_o(ch_evt_o), .user_evt_o(user_evt_o));

/* tb/evr_gen_model.sv */
// Peripheral event generator model, changes one level after a delay
`timescale 1ns/1ps
module evr_gen_model (
  // Clock
  input wire logic clk_i,
  // Command
  input wire logic set_i,
  input wire logic [5:0] idx_i,
  input wire logic lvl_i,
  input wire logic [2:0] dly_i,
  // Generator levels
  output logic [evr_pkg::NUM_GEN-1:0] gen_o
);
  logic [3:0] cnt = 4'h0;
  logic [5:0] idx = 6'h00;
  logic lvl = 1'b0;
  initial gen_o = '0;
  always @(posedge clk_i) begin
    if (set_i) begin
      idx <= idx_i;
      lvl <= lvl_i;
      cnt <= {1'b0, dly_i} + 4'h1;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        gen_o[idx] <= lvl;
      end
    end
  end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the event routing configuration block
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  evr_pkg::evr_wb_req_t req = '0;
  evr_pkg::evr_wb_rsp_t rsp;
  logic [evr_pkg::NUM_GEN-1:0] gen;
  logic [evr_pkg::NUM_CH-1:0] ch;
  logic [evr_pkg::NUM_USER-1:0] usr;
  logic set = 1'b0;
  logic [5:0] gidx = 6'h00;
  logic glvl = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  int kc;
  int ku;
  always #12.5 clk_i = ~clk_i;
  evr_route uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .gen_evt_i(gen), .ch_evt_o(ch), .user_evt_o(usr));
  evr_gen_model gm (.clk_i(clk_i), .set_i(set), .idx_i(gidx), .lvl_i(glvl),
    .dly_i(3'h2), .gen_o(gen));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
    // Ack is judged at the rising edge, where the write commits and read data stands
    do begin
      @(posedge clk_i);
      t++;
    end while (rsp.ack !== 1'b1 && t < 20);
    if (t >= 20) error_cnt++;
    rd = rsp.dat;
    req <= '0;
  endtask
  task automatic gset(input logic [5:0] i, input logic l);
    @(posedge clk_i);
    set <= 1'b1;
    gidx <= i;
    glvl <= l;
    @(posedge clk_i);
    set <= 1'b0;
  endtask
  // Index -1 watches every channel or user at once
  task automatic watch(input int n, input int c, input int u);
    kc = 0;
    ku = 0;
    repeat (n) begin
      @(negedge clk_i);
      kc += (c < 0) ? int'((|ch) !== 1'b0) : int'(ch[c] !== 1'b0);
      ku += (u < 0) ? int'((|usr) !== 1'b0) : int'(usr[u] !== 1'b0);
    end
  endtask
  task automatic t_reset;
    wb(1'b0, evr_pkg::ADR_CHANNEL, 4'hF, 32'h0);
    chk("chan_rst", 32'h0, rd);
    wb(1'b0, evr_pkg::ADR_USER, 4'hF, 32'h0);
    chk("user_rst", 32'h0, rd);
    wb(1'b1, 4'h0, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
  endtask
  task automatic t_paths;
    for (int p = 0; p < 2; p++) begin
      for (int e = 0; e < 4; e++) begin
        wb(1'b1, evr_pkg::ADR_CHANNEL, 4'hF, {4'h0, e[1:0], p[1:0], 24'h3B0002});
        wb(1'b0, evr_pkg::ADR_CHANNEL, 4'hF, 32'h0);
        chk("chan_cfg", {4'h0, e[1:0], p[1:0], 24'h3B0002}, rd);
        gset(6'd58, 1'b1);
        watch(12, 2, -1);
        chk("rise_cnt", e & 1, kc);
        gset(6'd58, 1'b0);
        watch(12, 2, -1);
        chk("fall_cnt", e >> 1, kc);
      end
    end
    $display("test paths done");
  endtask
  task automatic t_none;
    logic [7:0] gs [3] = '{8'h3B, 8'h00, 8'h3C};
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, evr_pkg::ADR_CHANNEL, 4'hF, {4'h0, 2'h3, (k == 0) ? 2'h3 : 2'h0, gs[k], 16'h0002});
      gset(6'd58, 1'b1);
      watch(12, -1, -1);
      chk("no_rise", 32'h0, kc);
      gset(6'd58, 1'b0);
      watch(12, -1, -1);
      chk("no_fall", 32'h0, kc);
    end
    $display("test none done");
  endtask
  task automatic t_async;
    wb(1'b1, evr_pkg::ADR_CHANNEL, 4'hF, 32'h020C_0003);
    gset(6'd11, 1'b1);
    watch(8, -1, -1);
    chk("async_hi", 32'h1, ch[3]);
    gset(6'd11, 1'b0);
    watch(8, -1, -1);
    chk("async_lo", 32'h0, ch[3]);
    $display("test async done");
  endtask
  // User map word, channel word, expected channel and user pulse counts
  task automatic t_inject;
    logic [33:0] tb [7] = '{{2'h3, 32'h060D_0105}, {2'h0, 32'h060D_0005},
      {2'h2, 32'h000D_0105}, {2'h2, 32'h090D_0105}, {2'h0, 32'h060D_0108},
      {2'h3, 32'h080D_0107}, {2'h3, 32'h010D_0100}};
    for (int k = 0; k < 7; k++) begin
      wb(1'b1, evr_pkg::ADR_USER, 4'h3, {16'h0, tb[k][31:16]});
      wb(1'b1, evr_pkg::ADR_CHANNEL, 4'h3, {16'h0, tb[k][15:0]});
      watch(6, -1, -1);
      chk("chan_evt", tb[k][33], kc);
      chk("user_evt", tb[k][32], ku);
    end
    wb(1'b1, evr_pkg::ADR_CHANNEL, 4'h1, 32'h0000_0008);
    wb(1'b0, evr_pkg::ADR_CHANNEL, 4'hF, 32'h0);
    chk("chan_rsvd", 32'h0000_0008, rd);
    wb(1'b1, evr_pkg::ADR_CHANNEL, 4'h3, 32'h0000_0105);
    wb(1'b0, evr_pkg::ADR_CHANNEL, 4'hF, 32'h0);
    chk("inject_rd", 32'h0000_0005, rd);
    wb(1'b1, evr_pkg::ADR_USER, 4'h3, 32'h0000_060D);
    wb(1'b0, evr_pkg::ADR_USER, 4'hF, 32'h0);
    chk("user_map", 32'h0000_060D, rd);
    $display("test inject done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_paths;
    t_none;
    t_async;
    t_inject;
    final_report;
  end
  // The whole sequence needs well under a thousand cycles
  initial begin
    repeat (6000) @(posedge clk_i);
    error_cnt++;
    final_report;
  end
endmodule
